// *** trace_bus_control_pkg.sv ***
package trace_ctl_pkg;
    // register map
    localparam logic [11:0] CTL_OFFSET     = 12'h110;
    // field positions inside trace_bus_control
    localparam int unsigned POS_PRIV       = 0;
    localparam int unsigned POS_NS         = 1;
    localparam int unsigned POS_ATTR_LO    = 2;
    localparam int unsigned POS_ORG        = 7;
    localparam int unsigned POS_ATTR_HI    = 16;
    // reset values
    localparam logic [7:0]  ATTR_RESET     = 8'h00;
    localparam logic        ORG_RESET      = 1'b0;
    localparam logic        PRIV_RESET     = 1'b0;
    // bus families for the single-code encoding
    typedef enum logic [1:0] {
        BUS_AXI3     = 2'h0,
        BUS_AXI4     = 2'h1,
        BUS_COHERENT = 2'h2
    } bus_kind_t;
    // attribute format capability values
    localparam logic [1:0]  FMT_SINGLE_SCAT = 2'h0;
    localparam logic        FMT_SPLIT_BIT   = 1'b1;
    // security implementation kinds
    typedef enum logic [2:0] {
        SEC_BOTH_RW     = 3'h0,
        SEC_BOTH_NS     = 3'h1,
        SEC_BOTH_S      = 3'h2,
        SEC_S_ONLY_RO   = 3'h3,
        SEC_S_ONLY_RW   = 3'h4,
        SEC_NS_ONLY_RO  = 3'h5,
        SEC_NS_ONLY_RW  = 3'h6
    } sec_kind_t;
    // issue state machine, one-hot
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_ACTIVE = 3'b010,
        ST_REFUSE = 3'b100
    } issue_state_t;
    // device-kind inner codes when outer nibble is zero, and the non-cacheable outer code
    localparam logic [3:0]  DEV_NGNRNE = 4'h0;
    localparam logic [3:0]  DEV_NGNRE  = 4'h4;
    localparam logic [3:0]  DEV_NGRE   = 4'h8;
    localparam logic [3:0]  DEV_GRE    = 4'hc;
    localparam logic [3:0]  SPLIT_NC   = 4'h4;
    // cache codes driven for the split encoding
    localparam logic [3:0]  CACHE_DEV  = 4'h0;
    localparam logic [3:0]  CACHE_DEVB = 4'h1;
    localparam logic [3:0]  CACHE_NC   = 4'h3;
    localparam logic [3:0]  CACHE_WT   = 4'he;
    localparam logic [3:0]  CACHE_WB   = 4'hf;
endpackage : trace_ctl_pkg

// *** attr_legalise.sv ***
`timescale 1ns/1ps
module attr_legalise
    import trace_ctl_pkg::*;
#(
    parameter trace_ctl_pkg::bus_kind_t BUS_KIND = trace_ctl_pkg::BUS_AXI4,
    parameter bit SPLIT      = 1'b0,  // split outer/inner format
    parameter bit EXT_SET    = 1'b0,  // extended single-code set
    parameter bit INNER_SUP  = 1'b1   // separate inner attributes
) (
    input  wire logic [7:0] code_i,   // code as written
    output logic      [7:0] code_o    // supported code
);
    logic ok;
    // legality per encoding family
    always_comb begin
        ok = 1'b0;
        if (SPLIT) begin
            if (code_i[7:4] == 4'h0) begin
                ok = (code_i[3:0] == DEV_NGNRNE) || (code_i[3:0] == DEV_NGNRE) ||
                     (code_i[3:0] == DEV_NGRE) || (code_i[3:0] == DEV_GRE);
            end else if (INNER_SUP) begin
                ok = (code_i[3:0] != 4'h0);
            end else begin
                ok = (code_i[3:0] == 4'h0);
            end
        end else if (BUS_KIND == BUS_COHERENT) begin
            ok = (code_i == 8'h00);
        end else if (BUS_KIND == BUS_AXI3) begin
            unique case (code_i)
                8'h00, 8'h01, 8'h02, 8'h03, 8'h06,
                8'h07, 8'h0a, 8'h0b, 8'h0e, 8'h0f: ok = 1'b1;
                default: ok = 1'b0;
            endcase
        end else if (EXT_SET) begin
            unique case (code_i)
                8'h00, 8'h11, 8'h22, 8'h33, 8'ha6, 8'hae,
                8'hb7, 8'hbf, 8'he6, 8'hee, 8'hf7, 8'hff: ok = 1'b1;
                default: ok = 1'b0;
            endcase
        end else begin
            unique case (code_i)
                8'h00, 8'h01, 8'h02, 8'h03,
                8'h06, 8'h07, 8'h0e, 8'h0f: ok = 1'b1;
                default: ok = 1'b0;
            endcase
        end
    end
    // unsupported codes fall back to the strongest ordering type
    assign code_o = ok ? code_i : ATTR_RESET;
endmodule : attr_legalise

// *** sec_policy.sv ***
`timescale 1ns/1ps
module sec_policy
    import trace_ctl_pkg::*;
#(
    parameter trace_ctl_pkg::sec_kind_t SEC_KIND = trace_ctl_pkg::SEC_BOTH_RW
) (
    input  wire logic ns_stored_i,  // stored select bit
    output logic      ns_read_o,    // value software reads
    output logic      ns_bus_o,     // value driven on the bus
    output logic      refuse_o      // access must be skipped
);
    // fixed kinds ignore the store, rw kinds flag the missing space
    always_comb begin
        ns_read_o = ns_stored_i;
        refuse_o  = 1'b0;
        unique case (SEC_KIND)
            SEC_BOTH_NS, SEC_NS_ONLY_RO: ns_read_o = 1'b1;
            SEC_BOTH_S, SEC_S_ONLY_RO:   ns_read_o = 1'b0;
            SEC_S_ONLY_RW:  refuse_o = ns_stored_i;
            SEC_NS_ONLY_RW: refuse_o = !ns_stored_i;
            default:        refuse_o = 1'b0;
        endcase
        ns_bus_o = ns_read_o;
    end
endmodule : sec_policy

// *** trace_bus_control.sv ***
// Contract
// - bit 7 selects contiguous or linked-list buffer
// - select ignored while capture is disabled
// - bit 7 only with scatter; bit 6 zero
// - attribute is bits 19:16 and 5:2
// - format capability picks the attribute encoding
// - table reads share attributes in format 00; the code shares in format 00 only with scatter and always in split format, else table reads use CACHE_DEV
// - AXI3 accepts ten listed attribute codes
// - basic AXI4 accepts eight listed codes
// - extended AXI4 set splits allocate hints
// - coherent system accepts only code zero
// - unsupported code acts as compatible type
// - attribute field resets to zero
// - split upper nibble gives outer type
// - inner codes mirror outer meanings
// - outer zero makes inner the device kind
// - bit 1 zero secure, one non-secure
// - security bit fixed one, zero or writable
// - secure-only system flags set security bit
// - non-secure-only system flags cleared bit
// - single code drives bus cache signals directly
// - bit 0 privilege, reads one if absent
`timescale 1ns/1ps
module trace_bus_control
    import trace_ctl_pkg::*;
#(
    parameter bit                       NO_SCATTER = 1'b0,
    parameter logic [1:0]               ATTR_FMT   = 2'h0,
    parameter bit                       ATTR_IMPL  = 1'b1,
    parameter trace_ctl_pkg::bus_kind_t BUS_KIND   = trace_ctl_pkg::BUS_AXI4,
    parameter bit                       HAS_SWFIFO = 1'b0,
    parameter bit                       INNER_SUP  = 1'b1,
    parameter trace_ctl_pkg::sec_kind_t SEC_KIND   = trace_ctl_pkg::SEC_BOTH_RW,
    parameter bit                       PRIV_SUP   = 1'b1
) (
    input  wire logic        clk_i,          // component clock
    input  wire logic        arst_n_i,       // async reset, low
    input  wire logic        reg_sel_i,      // register access strobe
    input  wire logic        reg_write_i,    // 1 write, 0 read
    input  wire logic [11:0] reg_addr_i,     // byte offset
    input  wire logic [31:0] reg_wdata_i,    // write data
    output logic      [31:0] reg_rdata_o,    // read data, registered
    output logic             reg_ready_o,    // access complete
    input  wire logic        capture_en_i,   // trace capture enabled
    input  wire logic        issue_valid_i,  // engine wants a transfer
    input  wire logic        issue_table_i,  // transfer is a table read
    output logic             issue_ready_o,  // transfer accepted
    input  wire logic        done_i,         // transfer completed
    output logic             bus_valid_o,    // attributes in use
    output logic      [3:0]  arcache_o,      // read cache attributes
    output logic      [3:0]  awcache_o,      // write cache attributes
    output logic      [2:0]  prot_o,         // protection attributes
    output logic      [3:0]  outer_attr_o,   // split outer type
    output logic      [3:0]  inner_attr_o,   // split inner type
    output logic             linked_list_o,  // linked-list mode in effect
    output logic             mem_error_o     // one-cycle memory error
);
    localparam bit SPLIT    = ATTR_IMPL && ATTR_FMT[1];
    localparam bit EXT_SET  = HAS_SWFIFO || !NO_SCATTER;
    localparam bit SHARE_TB = ATTR_IMPL && (ATTR_FMT == FMT_SINGLE_SCAT) && !NO_SCATTER;

    // elaboration checks
    if (ATTR_FMT[1] && BUS_KIND != BUS_AXI4) begin : g_chk
        $error("split format is served only with the AXI4 default kind");
    end

    typedef struct packed {
        issue_state_t st;
        logic         org;
        logic [7:0]   attr;
        logic         ns;
        logic         priv;
        logic [31:0]  rdata;
        logic         ready;
        logic         err;
        logic         ll;
        logic [3:0]   arc;
        logic [3:0]   awc;
        logic [2:0]   prot;
        logic [3:0]   outer;
        logic [3:0]   inner;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic [7:0]  wr_attr;
    logic [7:0]  legal_attr;
    logic        ns_read;
    logic        ns_bus;
    logic        refuse;
    logic        hit;
    logic        priv_read;
    logic [31:0] rd_word;
    logic [3:0]  split_cache;
    logic [3:0]  cur_arc;
    logic [3:0]  cur_awc;

    // write data assembled into the eight-bit attribute
    assign wr_attr = {reg_wdata_i[POS_ATTR_HI +: 4], reg_wdata_i[POS_ATTR_LO +: 4]};

    attr_legalise #(
        .BUS_KIND  (BUS_KIND),
        .SPLIT     (SPLIT),
        .EXT_SET   (EXT_SET),
        .INNER_SUP (INNER_SUP)
    ) u_legal (
        .code_i (wr_attr),
        .code_o (legal_attr)
    );

    sec_policy #(
        .SEC_KIND (SEC_KIND)
    ) u_sec (
        .ns_stored_i (s_q.ns),
        .ns_read_o   (ns_read),
        .ns_bus_o    (ns_bus),
        .refuse_o    (refuse)
    );

    assign hit       = (reg_addr_i == CTL_OFFSET);
    assign priv_read = PRIV_SUP ? s_q.priv : 1'b1;

    // read image; reserved bits and absent attribute and select fields read zero
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_word[POS_PRIV] = priv_read;
        rd_word[POS_NS]   = ns_read;
        if (ATTR_IMPL) begin
            rd_word[POS_ATTR_LO +: 4] = s_q.attr[3:0];
            rd_word[POS_ATTR_HI +: 4] = s_q.attr[7:4];
        end
        if (!NO_SCATTER) begin
            rd_word[POS_ORG] = s_q.org;
        end
    end

    // outer/inner pair reduced to one cache code; coarse but ordered
    always_comb begin
        if (s_q.attr[7:4] == 4'h0) begin
            split_cache = (s_q.attr[3:0] == DEV_NGNRNE) ? CACHE_DEV : CACHE_DEVB;
        end else if (s_q.attr[7:4] == SPLIT_NC) begin
            split_cache = CACHE_NC;
        end else if (s_q.attr[6]) begin
            split_cache = CACHE_WB;
        end else begin
            split_cache = CACHE_WT;
        end
    end

    // cache codes for a data write or a table read
    always_comb begin
        if (SPLIT) begin
            cur_arc = split_cache;
            cur_awc = split_cache;
        end else begin
            cur_awc = s_q.attr[3:0];
            cur_arc = (s_q.attr[7:4] != 4'h0) ? s_q.attr[7:4] : s_q.attr[3:0];
        end
        if (issue_table_i && !SHARE_TB && !SPLIT) begin
            cur_arc = CACHE_DEV;
        end
    end

    assign issue_ready_o = (s_q.st == ST_IDLE);

    // next state
    always_comb begin
        s_d       = s_q;
        s_d.ready = 1'b0;
        s_d.err   = 1'b0;
        // register access, one-cycle answer
        if (reg_sel_i) begin
            s_d.ready = 1'b1;
            s_d.rdata = (hit && !reg_write_i) ? rd_word : 32'h0000_0000;
            if (hit && reg_write_i) begin
                if (!NO_SCATTER) begin
                    s_d.org = reg_wdata_i[POS_ORG];
                end
                if (ATTR_IMPL) begin
                    s_d.attr = legal_attr;
                end
                s_d.ns   = reg_wdata_i[POS_NS];
                s_d.priv = PRIV_SUP ? reg_wdata_i[POS_PRIV] : 1'b1;
            end
        end
        // organisation only matters while capturing
        s_d.ll = capture_en_i && s_q.org;
        unique case (s_q.st)
            ST_IDLE: begin
                if (issue_valid_i) begin
                    if (refuse) begin
                        s_d.st  = ST_REFUSE;
                        s_d.err = 1'b1;
                    end else begin
                        s_d.st    = ST_ACTIVE;
                        s_d.arc   = cur_arc;
                        s_d.awc   = cur_awc;
                        s_d.prot  = {1'b0, ns_bus, priv_read};
                        s_d.outer = SPLIT ? s_q.attr[7:4] : 4'h0;
                        s_d.inner = SPLIT ? s_q.attr[3:0] : 4'h0;
                    end
                end
            end
            ST_ACTIVE: begin
                if (done_i) begin
                    s_d.st = ST_IDLE;
                end
            end
            ST_REFUSE: begin
                s_d.st = ST_IDLE;
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
    end

    // single state register
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_q       <= '0;
            s_q.st    <= ST_IDLE;
            s_q.org   <= ORG_RESET;
            s_q.attr  <= ATTR_RESET;
            s_q.priv  <= PRIV_SUP ? PRIV_RESET : 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata_o   = s_q.rdata;
    assign reg_ready_o   = s_q.ready;
    assign bus_valid_o   = (s_q.st == ST_ACTIVE);
    assign arcache_o     = s_q.arc;
    assign awcache_o     = s_q.awc;
    assign prot_o        = s_q.prot;
    assign outer_attr_o  = s_q.outer;
    assign inner_attr_o  = s_q.inner;
    assign linked_list_o = s_q.ll;
    assign mem_error_o   = s_q.err;

    // attributes frozen for the whole transfer
    AST_HOLD: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (bus_valid_o && !done_i) |=> ($stable(awcache_o) && $stable(arcache_o) && $stable(prot_o)))
        else $error("attributes changed during a transfer");

    // linked-list mode off from the cycle after capture is off
    AST_ORG_GATE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !capture_en_i |=> !linked_list_o)
        else $error("linked-list mode while capture disabled");

    // bit 6 and, without scatter, bit 7 read zero
    AST_RES_BITS: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        reg_ready_o |-> (!reg_rdata_o[6] && !(NO_SCATTER && reg_rdata_o[POS_ORG])))
        else $error("reserved bit reads one");

    // written organisation bit readable on a following read
    AST_ORG_RW: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (reg_sel_i && reg_write_i && hit && !NO_SCATTER) |=> (s_q.org == $past(reg_wdata_i[POS_ORG])))
        else $error("organisation bit not stored");

    // refused transfer gives a single error pulse and no bus activity
    AST_REFUSE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        mem_error_o |-> (!bus_valid_o ##1 (!mem_error_o && issue_ready_o)))
        else $error("memory error not a clean single pulse");

    // security bit on the bus matches the fixed both-space kinds
    AST_NS_FIXED: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        bus_valid_o |-> ((SEC_KIND == SEC_BOTH_NS) ? prot_o[1] :
                         (SEC_KIND == SEC_BOTH_S) ? !prot_o[1] : 1'b1))
        else $error("fixed security attribute violated");

    // without privilege control the bit reads one
    AST_PRIV: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (reg_ready_o && !PRIV_SUP && $past(hit) && !$past(reg_write_i)) |-> reg_rdata_o[POS_PRIV])
        else $error("privilege bit must read one");

    // coherent system stores only code zero
    AST_COHERENT: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (BUS_KIND == BUS_COHERENT && !SPLIT) |-> (s_q.attr == 8'h00))
        else $error("non-zero code in coherent system");

    // an accepted issue starts the transfer on the next edge
    AST_ISSUE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (issue_ready_o && issue_valid_i && !refuse) |=> (bus_valid_o && (prot_o[1] == $past(ns_bus))))
        else $error("transfer did not start with current attributes");

    // register answer exactly one cycle after the strobe
    AST_ANSWER: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        reg_sel_i |=> reg_ready_o)
        else $error("register access not answered");

    // writes and unmapped reads carry zero data
    AST_RD_ZERO: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (reg_sel_i && !(hit && !reg_write_i)) |=> (reg_rdata_o == 32'h0000_0000))
        else $error("write or unmapped read returned data");

    // ready is a pulse, never raised without a strobe
    AST_RDY_PULSE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !reg_sel_i |=> !reg_ready_o)
        else $error("ready without a register access");

    // first edge after release still shows the reset attribute
    AST_RST_ATTR: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        $rose(arst_n_i) |-> (s_q.attr == ATTR_RESET))
        else $error("attribute not cleared by reset");

    // done closes the transfer and frees the issue port
    AST_DONE_END: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (bus_valid_o && done_i) |=> (!bus_valid_o && issue_ready_o))
        else $error("transfer did not end on done");

    // a refused request raises the error and never reaches the bus
    AST_REF_START: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (issue_ready_o && issue_valid_i && refuse) |=> (mem_error_o && !bus_valid_o))
        else $error("refused request reached the bus");

    // no transfer ever targets the missing security space
    AST_SPACE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        bus_valid_o |-> !((SEC_KIND == SEC_S_ONLY_RW && prot_o[1]) ||
                          (SEC_KIND == SEC_NS_ONLY_RW && !prot_o[1])))
        else $error("transfer aimed at the missing space");

    // single-code builds leave the split outputs at zero
    AST_NIBBLES: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (bus_valid_o && !SPLIT) |-> (outer_attr_o == 4'h0 && inner_attr_o == 4'h0))
        else $error("split attributes in single-code format");

    // unused bits 31:20 and 15:8 of the read image stay zero
    AST_RES_HIGH: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        reg_ready_o |-> (reg_rdata_o[31:20] == 12'h000 && reg_rdata_o[15:8] == 8'h00))
        else $error("unused read bits not zero");

    // linked-list output follows the stored select while capturing
    AST_LL_FOLLOW: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        capture_en_i |=> (linked_list_o == $past(s_q.org)))
        else $error("linked-list mode does not follow select");

    // a write keeps the legalised code, not the raw one
    AST_ATTR_STORE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (reg_sel_i && reg_write_i && hit && ATTR_IMPL) |=> (s_q.attr == $past(legal_attr)))
        else $error("attribute not stored as legalised code");
endmodule : trace_bus_control

// *** mem_partner.sv ***
`timescale 1ns/1ps
module mem_partner (
    input  wire logic       clk_i,    // component clock
    input  wire logic       arst_n_i, // async reset, low
    input  wire logic       busy_i,   // transfer active on the bus
    input  wire logic [7:0] lat_i,    // answer latency in cycles
    output logic            done_o    // one-cycle completion
);
    logic [7:0] cnt_q;

    // answers after lat_i cycles; driven off the sampling edge
    // so the design never sees done change at its own edge
    always @(negedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q  <= 8'h00;
            done_o <= 1'b0;
        end else if (done_o) begin
            cnt_q  <= 8'h00;
            done_o <= 1'b0;
        end else if (busy_i) begin
            if (cnt_q == lat_i) begin
                done_o <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end
endmodule : mem_partner

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import trace_ctl_pkg::*;
    logic clk_i, arst_n_i, sel, wr, cap_en, iv, itbl, done, rdy, bv, ll, merr;
    logic [11:0] addr;
    logic [31:0] wd, rd, rd2, rd3, d1, d2;
    logic [3:0]  arc, awc, out2, in2, arc3, awc3;
    logic [2:0]  prot, prot3;
    logic        bv2, err2;
    logic [7:0]  lat;
    int          err_count, comparisons, n;
    logic [7:0]  codes [8] = '{8'h00, 8'h11, 8'h22, 8'h33, 8'ha6, 8'hee, 8'hf7, 8'hff};

    trace_bus_control uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .reg_sel_i(sel), .reg_write_i(wr),
        .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rd), .reg_ready_o(rdy), .capture_en_i(cap_en),
        .issue_valid_i(iv), .issue_table_i(itbl), .issue_ready_o(), .done_i(done), .bus_valid_o(bv),
        .arcache_o(arc), .awcache_o(awc), .prot_o(prot), .outer_attr_o(), .inner_attr_o(),
        .linked_list_o(ll), .mem_error_o(merr));
    // second build: split format, secure-only memory with a writable select
    trace_bus_control #(.ATTR_FMT(2'h2), .SEC_KIND(SEC_S_ONLY_RW)) uut2 (.clk_i(clk_i),
        .arst_n_i(arst_n_i), .reg_sel_i(sel), .reg_write_i(wr), .reg_addr_i(addr), .reg_wdata_i(wd),
        .reg_rdata_o(rd2), .reg_ready_o(), .capture_en_i(cap_en), .issue_valid_i(iv),
        .issue_table_i(itbl), .issue_ready_o(), .done_i(done), .bus_valid_o(bv2), .arcache_o(),
        .awcache_o(), .prot_o(), .outer_attr_o(out2), .inner_attr_o(in2), .linked_list_o(),
        .mem_error_o(err2));
    // third build: basic set, fixed non-secure, no privilege or scatter
    trace_bus_control #(.NO_SCATTER(1'b1), .SEC_KIND(SEC_BOTH_NS), .PRIV_SUP(1'b0)) uut3 (.clk_i(clk_i),
        .arst_n_i(arst_n_i), .reg_sel_i(sel), .reg_write_i(wr), .reg_addr_i(addr), .reg_wdata_i(wd),
        .reg_rdata_o(rd3), .reg_ready_o(), .capture_en_i(cap_en), .issue_valid_i(iv),
        .issue_table_i(itbl), .issue_ready_o(), .done_i(done), .bus_valid_o(), .arcache_o(arc3),
        .awcache_o(awc3), .prot_o(prot3), .outer_attr_o(), .inner_attr_o(), .linked_list_o(),
        .mem_error_o());
    mem_partner mem (.clk_i(clk_i), .arst_n_i(arst_n_i), .busy_i(bv), .lat_i(lat), .done_o(done));

    // clock generation
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one register access; ready is due exactly one cycle after the strobe
    task automatic reg_acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                           output logic [31:0] r, output logic [31:0] r2);
        @(negedge clk_i);
        sel  = 1'b1;
        wr   = w;
        addr = a;
        wd   = d;
        @(negedge clk_i);
        sel = 1'b0;
        check({31'h0, rdy}, 32'h1);
        r  = rd;
        r2 = rd2;
    endtask : reg_acc

    function automatic logic [31:0] mk(input logic [7:0] a, input logic org, input logic ns, input logic pv);
        return {12'h000, a[7:4], 8'h00, org, 1'b1, a[3:0], ns, pv};
    endfunction : mk

    // request a transfer and hold it until the edge that takes it
    task automatic xfer(input logic tbl);
        @(negedge clk_i);
        iv   = 1'b1;
        itbl = tbl;
        n    = 0;
        while (uut.issue_ready_o !== 1'b1 && n < 20) begin
            @(negedge clk_i);
            n++;
        end
        @(negedge clk_i);
        iv = 1'b0;
    endtask : xfer

    task automatic print_verdict;
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    // watchdog at 20000 cycles, far beyond the 122 cycles the tests need
    initial begin
        #(25 * 20000);
        err_count++;
        print_verdict();
    end

    initial begin
        arst_n_i = 1'b0; sel = 1'b0; wr = 1'b0; addr = 12'h000; wd = 32'h0;
        cap_en = 1'b0; iv = 1'b0; itbl = 1'b0; lat = 8'h09;
        err_count = 0; comparisons = 0;
        repeat (4) @(negedge clk_i);
        arst_n_i = 1'b1;
        // reset state
        check({31'h0, uut.issue_ready_o}, 32'h1);
        check({31'h0, bv}, 32'h0);
        reg_acc(1'b0, CTL_OFFSET, 32'h0, d1, d2);
        check(d1, 32'h0);
        check(d2, 32'h0);
        check(rd3, 32'h3);
        // unmapped place: write ignored, read zero
        reg_acc(1'b1, 12'h114, 32'hffffffff, d1, d2);
        reg_acc(1'b0, 12'h114, 32'h0, d1, d2);
        check(d1, 32'h0);
        reg_acc(1'b0, CTL_OFFSET, 32'h0, d1, d2);
        check(d1, 32'h0);
        // select bit with capture off, then on
        reg_acc(1'b1, CTL_OFFSET, mk(8'hee, 1'b1, 1'b1, 1'b1), d1, d2);
        reg_acc(1'b0, CTL_OFFSET, 32'h0, d1, d2);
        check(d1, mk(8'hee, 1'b1, 1'b1, 1'b1) & ~32'h40);
        check(d2, mk(8'hee, 1'b1, 1'b1, 1'b1) & ~32'h40);
        check(rd3, 32'h3);
        repeat (2) @(negedge clk_i);
        check({31'h0, ll}, 32'h0);
        cap_en = 1'b1;
        repeat (2) @(negedge clk_i);
        check({31'h0, ll}, 32'h1);
        // eight of the twelve extended codes, alternating table reads and security space
        for (int i = 0; i < 8; i++) begin
            reg_acc(1'b1, CTL_OFFSET, mk(codes[i], 1'b1, i[0], i[1]), d1, d2);
            xfer(i[0]);
            check({31'h0, bv}, 32'h1);
            check({28'h0, arc}, {28'h0, (codes[i][7:4] != 4'h0) ? codes[i][7:4] : codes[i][3:0]});
            check({28'h0, awc}, {28'h0, codes[i][3:0]});
            check({29'h0, prot}, {29'h0, 1'b0, i[0], i[1]});
            check({31'h0, merr}, 32'h0);
            check({31'h0, err2}, {31'h0, i[0]});
            check({31'h0, bv2}, {31'h0, ~i[0]});
            // a refused request leaves the split outputs of the last issue
            check({28'h0, out2}, {28'h0, codes[(i / 2) * 2][7:4]});
            check({28'h0, in2}, {28'h0, codes[(i / 2) * 2][3:0]});
            // rewrite mid-transfer; the bus keeps the issued values
            reg_acc(1'b1, CTL_OFFSET, mk(8'h33, 1'b0, ~i[0], ~i[1]), d1, d2);
            check({24'h0, awc, arc}, {24'h0, codes[i][3:0], (codes[i][7:4] != 4'h0) ? codes[i][7:4] : codes[i][3:0]});
            check({29'h0, prot}, {29'h0, 1'b0, i[0], i[1]});
            n = 0;
            while (bv === 1'b1 && n < 30) begin
                @(negedge clk_i);
                n++;
            end
            check({31'h0, bv}, 32'h0);
            lat = i[0] ? 8'h09 : 8'h03;
        end
        // basic set, fixed non-secure, absent privilege, private table attributes
        reg_acc(1'b1, CTL_OFFSET, mk(8'h07, 1'b1, 1'b0, 1'b0), d1, d2);
        check(rd3, 32'h0);
        reg_acc(1'b0, CTL_OFFSET, 32'h0, d1, d2);
        check(rd3, mk(8'h07, 1'b0, 1'b1, 1'b1) & ~32'h40);
        xfer(1'b1);
        check({28'h0, arc3}, 32'h0);
        check({28'h0, awc3}, 32'h7);
        check({29'h0, prot3}, 32'h3);
        // device kinds in the split build
        reg_acc(1'b1, CTL_OFFSET, mk(8'h0c, 1'b0, 1'b0, 1'b0), d1, d2);
        reg_acc(1'b0, CTL_OFFSET, 32'h0, d1, d2);
        check(d2, mk(8'h0c, 1'b0, 1'b0, 1'b0) & ~32'h40);
        // reserved code is taken as the supported zero code
        reg_acc(1'b1, CTL_OFFSET, mk(8'h05, 1'b0, 1'b0, 1'b1), d1, d2);
        reg_acc(1'b0, CTL_OFFSET, 32'h0, d1, d2);
        check(d1, mk(8'h00, 1'b0, 1'b0, 1'b1) & ~32'h40);
        check(rd3, 32'h3);
        print_verdict();
    end
endmodule : testbench
